// ==== logic/flsc_top.sv ====
`timescale 1ns/1ps
`include "flsc_cfg.svh"
// What this block does
// - Paged overcurrent fault threshold, default 0xdbb8.
// - Paged overcurrent fault reaction byte, default zero.
// - Paged overcurrent warning threshold, default 0xda80.
// - Paged hot fault threshold, default 0xeb20.
// - Paged hot fault reaction byte, default 0xb8.
// - Paged hot warning threshold, default 0xeaa8.
// - Paged cold fault threshold, default 0xe580.
// - Paged cold fault reaction byte, default 0xb8.
// - Wait turn-on delay before the rise ramp.
// - Rise ramp lasts the programmed rise time.
// - Flag timeout if output not above undervoltage.
// - Paged turn-on timeout reaction byte, default 0xb8.
// - Wait turn-off delay before the fall ramp.
// - Fall ramp lasts the programmed fall time.
// - Warn if output not below eighth in time.
// - Paged volatile one-byte status summary.
// - Paged volatile two-byte status summary.
// - Shared input supply status byte.
// - Paged temperature status byte.
// - Times use five-bit exponent, eleven-bit mantissa.
// - Voltages are unsigned, scaled by two to minus twelve.
// - Page register picks channel, resets to zero.
// - Store command copies all settings to nonvolatile copy.
module flsc_top #(
  parameter int CHANNELS  = 2,
  parameter int MS_CYCLES = `FLSC_MS_NS / `FLSC_CLK_NS
) (
  input  wire logic                REF_CLK_I,
  input  wire logic                RSTN_I,
  input  wire logic                CE_I,
  input  wire logic                CMD_STB_I,
  input  wire logic                CMD_WR_I,
  input  wire logic [7:0]          CMD_CODE_I,
  input  wire logic [15:0]         CMD_WDATA_I,
  input  wire logic [CHANNELS-1:0] RUN_I,
  input  wire logic [CHANNELS-1:0] OUT_ABOVE_UV_I,
  input  wire logic [CHANNELS-1:0] OUT_BELOW_EIGHTH_I,
  input  wire logic [CHANNELS-1:0] OC_FAULT_I,
  input  wire logic [CHANNELS-1:0] OC_WARN_I,
  input  wire logic [CHANNELS-1:0] HOT_FAULT_I,
  input  wire logic [CHANNELS-1:0] HOT_WARN_I,
  input  wire logic [CHANNELS-1:0] COLD_FAULT_I,
  input  wire logic                IN_OV_FAULT_I,
  input  wire logic                IN_UV_WARN_I,
  output logic                     ACK_O,
  output logic                     ERR_O,
  output logic [15:0]              RDATA_O,
  output logic                     NV_STORE_O,
  output logic [CHANNELS-1:0]      OUT_ON_O,
  output logic [CHANNELS-1:0]      RISE_O,
  output logic [CHANNELS-1:0]      FALL_O
);

  localparam int NREG = 20;
  localparam int NBYTE_FIRST = 12;
  localparam int NSHARED_FIRST = 18;

  // Converts a time in exponent-mantissa form to whole milliseconds.
  function automatic logic [15:0] em_to_ms(input logic [15:0] v);
    logic signed [4:0]  e;
    logic signed [10:0] m;
    logic [31:0]        mag;
    logic [31:0]        q;
    logic [4:0]         sh;
    e   = v[15:11];
    m   = v[10:0];
    mag = 32'h0;
    q   = 32'h0;
    sh  = 5'h0;
    if (m > 0) begin
      mag = {22'h0, m[9:0]};
      if (e >= 0) begin
        q = mag << e;
      end else begin
        sh = 5'(-e);
        q  = mag >> sh;
        if ((q << sh) != mag) begin
          q = q + 32'h1; // Round up so a short time never becomes zero.
        end
      end
    end
    em_to_ms = (q > 32'hffff) ? 16'hffff : q[15:0];
  endfunction

  // Reset value of each stored setting.
  function automatic logic [15:0] def_val(input int i);
    case (i)
      0:  def_val = `FLSC_DEF_UVF_LIM;
      1:  def_val = `FLSC_DEF_OCF_LIM;
      2:  def_val = `FLSC_DEF_OCW_LIM;
      3:  def_val = `FLSC_DEF_HOTF_LIM;
      4:  def_val = `FLSC_DEF_HOTW_LIM;
      5:  def_val = `FLSC_DEF_COLDF_LIM;
      6:  def_val = `FLSC_DEF_ON_WAIT;
      7:  def_val = `FLSC_DEF_ON_RAMP;
      8:  def_val = `FLSC_DEF_ON_TMO;
      9:  def_val = `FLSC_DEF_OFF_WAIT;
      10: def_val = `FLSC_DEF_OFF_RAMP;
      11: def_val = `FLSC_DEF_OFF_TMO;
      12: def_val = `FLSC_DEF_UVF_RSP;
      13: def_val = `FLSC_DEF_OCF_RSP;
      14: def_val = `FLSC_DEF_HOTF_RSP;
      15: def_val = `FLSC_DEF_COLDF_RSP;
      16: def_val = `FLSC_DEF_INOV_RSP;
      17: def_val = `FLSC_DEF_ON_TMO_RSP;
      18: def_val = `FLSC_DEF_INOV_LIM;
      default: def_val = `FLSC_DEF_INUV_LIM;
    endcase
  endfunction

  logic [15:0] cfg_reg [CHANNELS][NREG];
  logic [15:0] nv_reg  [CHANNELS][NREG];
  logic [7:0]  page_reg;
  logic [7:0]  vout_flg_reg [CHANNELS];
  logic [7:0]  iout_flg_reg [CHANNELS];
  logic [7:0]  temp_flg_reg [CHANNELS];
  logic [7:0]  in_flg_reg;
  logic [31:0] tick_cnt_reg;
  logic        ms_tick;
  logic        hit;
  logic [4:0]  idx;
  logic        wide;
  logic        paged;
  logic        ch_sel;
  logic        wr;
  logic        rd_ok;
  logic [15:0] rd_val;
  logic        clr_all;
  logic [CHANNELS-1:0] ton_flt;
  logic [CHANNELS-1:0] toff_wrn;

  // Decodes a command code into a storage index.
  always_comb begin
    hit = 1'b1;
    idx = 5'd0;
    case (CMD_CODE_I)
      `FLSC_CMD_UVF_LIM:    idx = 5'd0;
      `FLSC_CMD_OCF_LIM:    idx = 5'd1;
      `FLSC_CMD_OCW_LIM:    idx = 5'd2;
      `FLSC_CMD_HOTF_LIM:   idx = 5'd3;
      `FLSC_CMD_HOTW_LIM:   idx = 5'd4;
      `FLSC_CMD_COLDF_LIM:  idx = 5'd5;
      `FLSC_CMD_ON_WAIT:    idx = 5'd6;
      `FLSC_CMD_ON_RAMP:    idx = 5'd7;
      `FLSC_CMD_ON_TMO:     idx = 5'd8;
      `FLSC_CMD_OFF_WAIT:   idx = 5'd9;
      `FLSC_CMD_OFF_RAMP:   idx = 5'd10;
      `FLSC_CMD_OFF_TMO:    idx = 5'd11;
      `FLSC_CMD_UVF_RSP:    idx = 5'd12;
      `FLSC_CMD_OCF_RSP:    idx = 5'd13;
      `FLSC_CMD_HOTF_RSP:   idx = 5'd14;
      `FLSC_CMD_COLDF_RSP:  idx = 5'd15;
      `FLSC_CMD_INOV_RSP:   idx = 5'd16;
      `FLSC_CMD_ON_TMO_RSP: idx = 5'd17;
      `FLSC_CMD_INOV_LIM:   idx = 5'd18;
      `FLSC_CMD_INUV_LIM:   idx = 5'd19;
      default:              hit = 1'b0;
    endcase
    wide  = (idx < 5'(NBYTE_FIRST)) || (idx >= 5'(NSHARED_FIRST));
    paged = idx < 5'(NSHARED_FIRST);
  end

  // Paged commands use the page register; shared ones use slot zero.
  assign ch_sel  = paged ? page_reg[0] : 1'b0;
  assign wr      = CE_I && CMD_STB_I && CMD_WR_I;
  assign clr_all = wr && (CMD_CODE_I == `FLSC_CMD_CLEAR);

  // Read multiplexer; unknown codes and bad page values are refused.
  always_comb begin
    rd_ok  = 1'b1;
    rd_val = 16'h0;
    if (hit) begin
      rd_val = cfg_reg[ch_sel][idx];
    end else begin
      case (CMD_CODE_I)
        `FLSC_CMD_PAGE:     rd_val = {8'h0, page_reg};
        `FLSC_CMD_SUM_BYTE: rd_val = {8'h0, 1'b0, !OUT_ON_O[page_reg[0]],
                                      1'b0, iout_flg_reg[page_reg[0]][`FLSC_BIT_OC_FAULT],
                                      1'b0, |temp_flg_reg[page_reg[0]], 2'b0};
        `FLSC_CMD_SUM_WORD: rd_val = {|vout_flg_reg[page_reg[0]],
                                      |iout_flg_reg[page_reg[0]], |in_flg_reg, 5'h0,
                                      1'b0, !OUT_ON_O[page_reg[0]],
                                      1'b0, iout_flg_reg[page_reg[0]][`FLSC_BIT_OC_FAULT],
                                      1'b0, |temp_flg_reg[page_reg[0]], 2'b0};
        `FLSC_CMD_VOUT_FLG: rd_val = {8'h0, vout_flg_reg[page_reg[0]]};
        `FLSC_CMD_IOUT_FLG: rd_val = {8'h0, iout_flg_reg[page_reg[0]]};
        `FLSC_CMD_IN_FLG:   rd_val = {8'h0, in_flg_reg};
        `FLSC_CMD_TEMP_FLG: rd_val = {8'h0, temp_flg_reg[page_reg[0]]};
        `FLSC_CMD_CLEAR,
        `FLSC_CMD_STORE,
        `FLSC_CMD_RESTORE:  rd_val = 16'h0;
        default:            rd_ok  = 1'b0;
      endcase
    end
    if (CMD_WR_I && CMD_CODE_I == `FLSC_CMD_PAGE && CMD_WDATA_I[7:0] > 8'h01
        && CMD_WDATA_I[7:0] != `FLSC_PAGE_ALL) begin
      rd_ok = 1'b0;
    end
  end

  // Answer port: acknowledge or error one cycle after the strobe.
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ACK_O      <= 1'b0;
      ERR_O      <= 1'b0;
      RDATA_O    <= 16'h0;
      NV_STORE_O <= 1'b0;
    end else if (CE_I) begin
      ACK_O      <= CMD_STB_I && rd_ok;
      ERR_O      <= CMD_STB_I && !rd_ok;
      NV_STORE_O <= wr && (CMD_CODE_I == `FLSC_CMD_STORE);
      if (CMD_STB_I && !CMD_WR_I) begin
        RDATA_O <= rd_val;
      end
    end
  end

  // Page select register.
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      page_reg <= `FLSC_DEF_PAGE;
    end else if (wr && rd_ok && CMD_CODE_I == `FLSC_CMD_PAGE) begin
      page_reg <= CMD_WDATA_I[7:0];
    end
  end

  // Working settings and their nonvolatile copy; byte registers keep 8 bits.
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      for (int c = 0; c < CHANNELS; c++) begin
        for (int i = 0; i < NREG; i++) begin
          cfg_reg[c][i] <= def_val(i);
          nv_reg[c][i]  <= def_val(i);
        end
      end
    end else if (wr) begin
      if (CMD_CODE_I == `FLSC_CMD_STORE) begin
        nv_reg <= cfg_reg;
      end else if (CMD_CODE_I == `FLSC_CMD_RESTORE) begin
        cfg_reg <= nv_reg;
      end else if (hit) begin
        for (int c = 0; c < CHANNELS; c++) begin
          if (paged ? (page_reg == `FLSC_PAGE_ALL || 1'(c) == page_reg[0]) : c == 0) begin
            cfg_reg[c][idx] <= wide ? CMD_WDATA_I : {8'h0, CMD_WDATA_I[7:0]};
          end
        end
      end
    end
  end

  // Free-running millisecond tick for the sequencing timers.
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      tick_cnt_reg <= 32'h0;
    end else if (CE_I) begin
      tick_cnt_reg <= ms_tick ? 32'h0 : tick_cnt_reg + 32'h1;
    end
  end
  assign ms_tick = tick_cnt_reg == 32'(MS_CYCLES - 1);

  // Shared input flags: set wins over a write-one clear.
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      in_flg_reg <= 8'h0;
    end else if (CE_I) begin
      in_flg_reg <= (clr_all ? 8'h0 : in_flg_reg & ~((wr && CMD_CODE_I == `FLSC_CMD_IN_FLG)
                    ? CMD_WDATA_I[7:0] : 8'h0))
                    | (8'(IN_OV_FAULT_I) << `FLSC_BIT_OV_FAULT)
                    | (8'(IN_UV_WARN_I) << `FLSC_BIT_UV_WARN);
    end
  end

  for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
    flsc_pkg::flsc_seq_type state_reg;
    flsc_pkg::flsc_seq_type state_next;
    logic [15:0] cnt_reg;
    logic [15:0] ton_cnt_reg;
    logic        uv_ok_reg;
    logic        sel;
    logic [7:0]  vclr;
    logic [7:0]  iclr;
    logic [7:0]  tclr;

    assign sel  = wr && (page_reg == `FLSC_PAGE_ALL || page_reg[0] == 1'(c));
    assign vclr = (sel && CMD_CODE_I == `FLSC_CMD_VOUT_FLG) ? CMD_WDATA_I[7:0] : 8'h0;
    assign iclr = (sel && CMD_CODE_I == `FLSC_CMD_IOUT_FLG) ? CMD_WDATA_I[7:0] : 8'h0;
    assign tclr = (sel && CMD_CODE_I == `FLSC_CMD_TEMP_FLG) ? CMD_WDATA_I[7:0] : 8'h0;

    // Next sequencing state from run level, timers and output monitors.
    always_comb begin
      state_next = state_reg;
      unique case (state_reg)
        flsc_pkg::SEQ_OFF:
          if (RUN_I[c]) state_next = flsc_pkg::SEQ_ON_WAIT;
        flsc_pkg::SEQ_ON_WAIT:
          if (!RUN_I[c]) state_next = flsc_pkg::SEQ_OFF;
          else if (cnt_reg >= em_to_ms(cfg_reg[c][6])) state_next = flsc_pkg::SEQ_RISE;
        flsc_pkg::SEQ_RISE:
          if (!RUN_I[c]) state_next = flsc_pkg::SEQ_OFF_WAIT;
          else if (cnt_reg >= em_to_ms(cfg_reg[c][7])) state_next = flsc_pkg::SEQ_ON;
        flsc_pkg::SEQ_ON:
          if (!RUN_I[c]) state_next = flsc_pkg::SEQ_OFF_WAIT;
        flsc_pkg::SEQ_OFF_WAIT:
          if (RUN_I[c]) state_next = flsc_pkg::SEQ_ON;
          else if (cnt_reg >= em_to_ms(cfg_reg[c][9])) state_next = flsc_pkg::SEQ_FALL;
        flsc_pkg::SEQ_FALL:
          if (cnt_reg >= em_to_ms(cfg_reg[c][10])) state_next = flsc_pkg::SEQ_DECAY;
        flsc_pkg::SEQ_DECAY:
          if (OUT_BELOW_EIGHTH_I[c] || toff_wrn[c]) state_next = flsc_pkg::SEQ_OFF;
        default:
          state_next = flsc_pkg::SEQ_OFF;
      endcase
    end

    // Timeout events: turn-on measured from the rise start, decay from fall end.
    assign ton_flt[c]  = uv_ok_reg == 1'b0 && !OUT_ABOVE_UV_I[c]
                         && (state_reg == flsc_pkg::SEQ_RISE || state_reg == flsc_pkg::SEQ_ON)
                         && ton_cnt_reg >= em_to_ms(cfg_reg[c][8]);
    assign toff_wrn[c] = state_reg == flsc_pkg::SEQ_DECAY && !OUT_BELOW_EIGHTH_I[c]
                         && cnt_reg >= em_to_ms(cfg_reg[c][11]);

    // State register and per-state millisecond counter.
    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
        state_reg <= flsc_pkg::SEQ_OFF;
        cnt_reg   <= 16'h0;
      end else if (CE_I) begin
        state_reg <= state_next;
        if (state_next != state_reg) begin
          cnt_reg <= 16'h0;
        end else if (ms_tick && cnt_reg != 16'hffff) begin
          cnt_reg <= cnt_reg + 16'h1;
        end
      end
    end

    // Turn-on timeout counter runs from the rise start; uv_ok_reg latches once the output clears undervoltage.
    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
        ton_cnt_reg <= 16'h0;
        uv_ok_reg   <= 1'b0;
      end else if (CE_I) begin
        if (state_reg == flsc_pkg::SEQ_ON_WAIT) begin
          ton_cnt_reg <= 16'h0;
          uv_ok_reg   <= 1'b0;
        end else begin
          if (OUT_ABOVE_UV_I[c] || ton_flt[c]) uv_ok_reg <= 1'b1;
          if (ms_tick && ton_cnt_reg != 16'hffff) ton_cnt_reg <= ton_cnt_reg + 16'h1;
        end
      end
    end

    // Sticky channel flags: set wins over clear.
    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
        vout_flg_reg[c] <= 8'h0;
        iout_flg_reg[c] <= 8'h0;
        temp_flg_reg[c] <= 8'h0;
      end else if (CE_I) begin
        vout_flg_reg[c] <= (clr_all ? 8'h0 : vout_flg_reg[c] & ~vclr)
          | (8'(uv_ok_reg == 1'b0 && ton_flt[c]) << `FLSC_BIT_TON_FAULT)
          | (8'(toff_wrn[c]) << `FLSC_BIT_TOFF_WARN)
          | (8'(state_reg == flsc_pkg::SEQ_ON && !OUT_ABOVE_UV_I[c])
             << `FLSC_BIT_UV_FAULT);
        iout_flg_reg[c] <= (clr_all ? 8'h0 : iout_flg_reg[c] & ~iclr)
          | (8'(OC_FAULT_I[c]) << `FLSC_BIT_OC_FAULT)
          | (8'(OC_WARN_I[c]) << `FLSC_BIT_OC_WARN);
        temp_flg_reg[c] <= (clr_all ? 8'h0 : temp_flg_reg[c] & ~tclr)
          | (8'(HOT_FAULT_I[c]) << `FLSC_BIT_HOT_FAULT)
          | (8'(HOT_WARN_I[c]) << `FLSC_BIT_HOT_WARN)
          | (8'(COLD_FAULT_I[c]) << `FLSC_BIT_COLD_FAULT);
      end
    end

    // Sequencing state seen at the pins.
    assign OUT_ON_O[c] = state_reg != flsc_pkg::SEQ_OFF && state_reg != flsc_pkg::SEQ_ON_WAIT;
    assign RISE_O[c]   = state_reg == flsc_pkg::SEQ_RISE;
    assign FALL_O[c]   = state_reg == flsc_pkg::SEQ_FALL;
  end

endmodule // flsc_top

// ==== shared/flsc_cfg.svh ====
`ifndef FLSC_CFG_SVH
`define FLSC_CFG_SVH

// Command codes of the control and store commands.
`define FLSC_CMD_PAGE      8'h00
`define FLSC_CMD_CLEAR     8'h03
`define FLSC_CMD_STORE     8'h15
`define FLSC_CMD_RESTORE   8'h16
// Command codes of the paged word registers.
`define FLSC_CMD_UVF_LIM   8'h44
`define FLSC_CMD_OCF_LIM   8'h46
`define FLSC_CMD_OCW_LIM   8'h4a
`define FLSC_CMD_HOTF_LIM  8'h4f
`define FLSC_CMD_HOTW_LIM  8'h51
`define FLSC_CMD_COLDF_LIM 8'h53
`define FLSC_CMD_ON_WAIT   8'h60
`define FLSC_CMD_ON_RAMP   8'h61
`define FLSC_CMD_ON_TMO    8'h62
`define FLSC_CMD_OFF_WAIT  8'h64
`define FLSC_CMD_OFF_RAMP  8'h65
`define FLSC_CMD_OFF_TMO   8'h66
// Command codes of the paged byte registers.
`define FLSC_CMD_UVF_RSP   8'h45
`define FLSC_CMD_OCF_RSP   8'h47
`define FLSC_CMD_HOTF_RSP  8'h50
`define FLSC_CMD_COLDF_RSP 8'h54
`define FLSC_CMD_INOV_RSP  8'h56
`define FLSC_CMD_ON_TMO_RSP 8'h63
// Command codes of the shared word registers.
`define FLSC_CMD_INOV_LIM  8'h55
`define FLSC_CMD_INUV_LIM  8'h58
// Command codes of the status registers.
`define FLSC_CMD_SUM_BYTE  8'h78
`define FLSC_CMD_SUM_WORD  8'h79
`define FLSC_CMD_VOUT_FLG  8'h7a
`define FLSC_CMD_IOUT_FLG  8'h7b
`define FLSC_CMD_IN_FLG    8'h7c
`define FLSC_CMD_TEMP_FLG  8'h7d

// Reset values loaded as the nonvolatile defaults.
`define FLSC_DEF_UVF_LIM   16'h0e66
`define FLSC_DEF_OCF_LIM   16'hdbb8
`define FLSC_DEF_OCW_LIM   16'hda80
`define FLSC_DEF_HOTF_LIM  16'heb20
`define FLSC_DEF_HOTW_LIM  16'heaa8
`define FLSC_DEF_COLDF_LIM 16'he580
`define FLSC_DEF_ON_WAIT   16'h8000
`define FLSC_DEF_ON_RAMP   16'hd200
`define FLSC_DEF_ON_TMO    16'hd280
`define FLSC_DEF_OFF_WAIT  16'h8000
`define FLSC_DEF_OFF_RAMP  16'hd200
`define FLSC_DEF_OFF_TMO   16'hf258
`define FLSC_DEF_UVF_RSP   16'h00b8
`define FLSC_DEF_OCF_RSP   16'h0000
`define FLSC_DEF_HOTF_RSP  16'h00b8
`define FLSC_DEF_COLDF_RSP 16'h00b8
`define FLSC_DEF_INOV_RSP  16'h0080
`define FLSC_DEF_ON_TMO_RSP 16'h00b8
`define FLSC_DEF_INOV_LIM  16'hd3e0
`define FLSC_DEF_INUV_LIM  16'hcb26
`define FLSC_DEF_PAGE      8'h00
`define FLSC_PAGE_ALL      8'hff

// Status flag bit positions.
`define FLSC_BIT_UV_FAULT  4
`define FLSC_BIT_TON_FAULT 2
`define FLSC_BIT_TOFF_WARN 1
`define FLSC_BIT_OC_FAULT  7
`define FLSC_BIT_OC_WARN   5
`define FLSC_BIT_OV_FAULT  7
`define FLSC_BIT_UV_WARN   5
`define FLSC_BIT_HOT_FAULT 7
`define FLSC_BIT_HOT_WARN  6
`define FLSC_BIT_COLD_FAULT 4

// Time base: one millisecond counted at the 40 ns clock.
`define FLSC_MS_NS         1000000
`define FLSC_CLK_NS        40

`endif

// ==== shared/flsc_pkg.sv ====
package flsc_pkg;

  // Channel sequencing states, Gray coded along the path from SEQ_OFF to SEQ_DECAY.
  typedef enum logic [2:0] {
    SEQ_OFF      = 3'b000,
    SEQ_ON_WAIT  = 3'b001,
    SEQ_RISE     = 3'b011,
    SEQ_ON       = 3'b010,
    SEQ_OFF_WAIT = 3'b110,
    SEQ_FALL     = 3'b111,
    SEQ_DECAY    = 3'b101
  } flsc_seq_type;

endpackage

// ==== test/flsc_checker.sv ====
`timescale 1ns/1ps
module flsc_checker #(
  parameter int CHANNELS  = 2,
  parameter int MS_CYCLES = 4
) (
  input wire logic                REF_CLK_I,
  input wire logic                RSTN_I,
  input wire logic                CE_I,
  input wire logic                CMD_STB_I,
  input wire logic                CMD_WR_I,
  input wire logic [7:0]          CMD_CODE_I,
  input wire logic [15:0]         CMD_WDATA_I,
  input wire logic [CHANNELS-1:0] RUN_I,
  input wire logic                ACK_O,
  input wire logic                ERR_O,
  input wire logic [15:0]         RDATA_O,
  input wire logic                NV_STORE_O,
  input wire logic [CHANNELS-1:0] OUT_ON_O,
  input wire logic [CHANNELS-1:0] RISE_O,
  input wire logic [CHANNELS-1:0] FALL_O
);
  logic take;
  logic rd;
  // A command counts once it is strobed on an enabled edge.
  assign take = CE_I && CMD_STB_I;
  assign rd = take && !CMD_WR_I;
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!RSTN_I);
  answer_once_a: assert property (take |=> ACK_O != ERR_O)
    else $error("command not answered exactly once");
  no_spurious_a: assert property (CE_I && !CMD_STB_I |=> !ACK_O && !ERR_O)
    else $error("answer without a command");
  page_refuse_a: assert property (take && CMD_WR_I && CMD_CODE_I == 8'h00 &&
    !(CMD_WDATA_I[7:0] inside {8'h00, 8'h01, 8'hff}) |=> ERR_O)
    else $error("bad page value accepted");
  limit_read_a: assert property (rd && CMD_CODE_I inside {8'h46, 8'h4a, 8'h4f,
    8'h51, 8'h53, 8'h60, 8'h61, 8'h62, 8'h64, 8'h65, 8'h66} |=> ACK_O)
    else $error("limit read refused");
  byte_upper_a: assert property (rd && CMD_CODE_I inside {8'h47, 8'h50, 8'h54,
    8'h63} |=> ACK_O && RDATA_O[15:8] == 8'h00)
    else $error("byte read upper half not zero");
  store_pulse_a: assert property (take && CMD_WR_I && CMD_CODE_I == 8'h15
    |-> ##[1:2] NV_STORE_O)
    else $error("store command gave no store pulse");
  rise_on_a: assert property (RISE_O[0] |-> OUT_ON_O[0] && !FALL_O[0])
    else $error("rise ramp while output off or falling");
  fall_cause_a: assert property ($rose(FALL_O[0]) |-> !$past(RUN_I[0]))
    else $error("fall ramp without run low");
  stay_off_a: assert property (CE_I && !RUN_I[0] && !OUT_ON_O[0] |=> !OUT_ON_O[0])
    else $error("channel left off with run low");
endmodule // flsc_checker

// ==== test/flsc_host.sv ====
`timescale 1ns/1ps
module flsc_host (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic        err_i,
  input  wire logic [15:0] rdata_i,
  output logic             stb_o,
  output logic             wr_o,
  output logic [7:0]       code_o,
  output logic [15:0]      wdata_o
);
  // The command port is idle from time zero.
  initial begin
    stb_o = 1'b0;
    wr_o = 1'b0;
    code_o = 8'h00;
    wdata_o = 16'h0000;
  end
  // One access: a strobe over one edge, then the answer a cycle later.
  task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] wd,
                      output logic [15:0] rd, output logic ok);
    @(negedge clk_i);
    stb_o = 1'b1;
    wr_o = wr;
    code_o = code;
    wdata_o = wd;
    @(negedge clk_i);
    stb_o = 1'b0;
    wdata_o = ~wd; // Released data must not keep its last value.
    rd = rdata_i;
    ok = ack_i && !err_i;
  endtask
  // Selects the channel that later paged accesses reach.
  task automatic sel(input logic [7:0] pg);
    logic [15:0] rd;
    logic ok;
    xfer(1'b1, 8'h00, {8'h00, pg}, rd, ok);
  endtask
endmodule // flsc_host

// ==== test/flsc_tb_top.sv ====
`timescale 1ns/1ps
module fault_limit_sequencing_cmds_tb_top;
  localparam int M = 4;
  localparam logic [7:0] CD [20] = '{8'h44, 8'h45, 8'h46, 8'h47, 8'h4a, 8'h4f, 8'h50,
    8'h51, 8'h53, 8'h54, 8'h55, 8'h56, 8'h58, 8'h60, 8'h61, 8'h62, 8'h63, 8'h64, 8'h65, 8'h66};
  localparam logic [15:0] DF [20] = '{16'h0e66, 16'h00b8, 16'hdbb8, 16'h0000, 16'hda80,
    16'heb20, 16'h00b8, 16'heaa8, 16'he580, 16'h00b8, 16'hd3e0, 16'h0080, 16'hcb26,
    16'h8000, 16'hd200, 16'hd280, 16'h00b8, 16'h8000, 16'hd200, 16'hf258};
  localparam logic [7:0] FC [7] = '{8'h7b, 8'h7b, 8'h7d, 8'h7d, 8'h7d, 8'h7c, 8'h7c};
  localparam logic [7:0] FB [7] = '{8'h80, 8'h20, 8'h80, 8'h40, 8'h10, 8'h80, 8'h20};
  logic        ref_clk, rstn, ce, stb, wr, ack, err, nv_store, ok, in_ov, in_uv;
  logic [7:0]  code;
  logic [15:0] wdata, rdata, rd, m, r0, r1;
  logic [1:0]  run, above_uv, below_eighth, out_on, rise, fall;
  logic [6:0]  ev;
  logic [4:0]  ev0;
  logic [31:0] seed;
  int          err_total, total_checks, w, n;
  flsc_host host (.clk_i(ref_clk), .ack_i(ack), .err_i(err), .rdata_i(rdata), .stb_o(stb),
    .wr_o(wr), .code_o(code), .wdata_o(wdata));
  flsc_top #(.CHANNELS(2), .MS_CYCLES(M)) dut (.REF_CLK_I(ref_clk), .RSTN_I(rstn),
    .CE_I(ce), .CMD_STB_I(stb), .CMD_WR_I(wr), .CMD_CODE_I(code), .CMD_WDATA_I(wdata),
    .RUN_I(run), .OUT_ABOVE_UV_I(above_uv), .OUT_BELOW_EIGHTH_I(below_eighth),
    .OC_FAULT_I({ev[0], ev0[0]}), .OC_WARN_I({ev[1], ev0[1]}),
    .HOT_FAULT_I({ev[2], ev0[2]}), .HOT_WARN_I({ev[3], ev0[3]}),
    .COLD_FAULT_I({ev[4], ev0[4]}), .IN_OV_FAULT_I(ev[5]),
    .IN_UV_WARN_I(ev[6]), .ACK_O(ack), .ERR_O(err), .RDATA_O(rdata),
    .NV_STORE_O(nv_store), .OUT_ON_O(out_on), .RISE_O(rise), .FALL_O(fall));
  // Free running 25 MHz clock.
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // Xorshift source, so every run draws the same values.
  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction
  // Whole milliseconds of an exponent and mantissa time, rounded up.
  function automatic int em_ms(input logic [15:0] v);
    int e, mt;
    e = $signed(v[15:11]);
    mt = $signed(v[10:0]);
    if (e >= 0) return mt <<< e;
    return (mt + (1 << -e) - 1) >>> -e;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] c, input logic [15:0] exp);
    host.xfer(1'b0, c, 16'h0000, rd, ok);
    chk({15'h0, ok}, 16'h0001, "read ack");
    chk(rd, exp, "read data");
  endtask
  task automatic wcmd(input logic [7:0] c, input logic [15:0] d);
    host.xfer(1'b1, c, d, rd, ok);
    chk({15'h0, ok}, 16'h0001, "write ack");
  endtask
  // Cycles until ramp flag rises, then cycles it stays high; checks both spans.
  task automatic ramp(input logic f, input int wms, input int rms);
    w = 0;
    n = 0;
    while ((f ? fall[0] : rise[0]) !== 1'b1 && w < 2000) begin
      @(negedge ref_clk);
      w++;
    end
    while ((f ? fall[0] : rise[0]) === 1'b1 && n < 2000) begin
      @(negedge ref_clk);
      n++;
    end
    chk(16'(w >= (wms - 1) * M + 1 && w <= wms * M + 2), 16'h1, "delay");
    chk(16'(n >= (rms - 1) * M + 1 && n <= rms * M + 2), 16'h1, "ramp");
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Hang guard.
  initial begin
    #(20000 * 40);
    err_total++;
    close_out();
  end
  // Main sequence.
  initial begin
    {rstn, ce, run, above_uv, below_eighth, ev, ev0} = '0;
    seed = 32'd46;
    err_total = 0;
    total_checks = 0;
    repeat (6) @(negedge ref_clk);
    rstn = 1'b1;
    ce = 1'b1;
    for (int p = 0; p < 2; p++) begin
      host.sel(8'(p));
      for (int i = 0; i < 20; i++) rchk(CD[i], DF[i]);
    end
    host.sel(8'h00);
    wcmd(8'h60, 16'h0002);
    run[0] = 1'b1;
    ramp(1'b0, 2, em_ms(16'hd200));
    repeat (3 * M) @(negedge ref_clk);
    rchk(8'h7a, 16'h0014);
    above_uv[0] = 1'b1;
    wcmd(8'h03, 16'h0000);
    rchk(8'h7a, 16'h0000);
    wcmd(8'h64, 16'h0001);
    run[0] = 1'b0;
    ramp(1'b1, 1, em_ms(16'hd200));
    repeat ((em_ms(16'hf258) + 1) * M) @(negedge ref_clk);
    chk({15'h0, out_on[0]}, 16'h0000, "channel off");
    rchk(8'h7a, 16'h0002);
    rchk(8'h78, 16'h0040);
    rchk(8'h79, 16'h8040);
    wcmd(8'h7a, 16'h00ff);
    rchk(8'h7a, 16'h0000);
    // Channel one on and off with defaults; the decay ends as soon as the output is low.
    host.sel(8'h01);
    above_uv[1] = 1'b1;
    run[1] = 1'b1;
    repeat (12 * M) @(negedge ref_clk);
    run[1] = 1'b0;
    below_eighth[1] = 1'b1;
    repeat (12 * M) @(negedge ref_clk);
    chk({15'h0, out_on[1]}, 16'h0000, "fast decay off");
    rchk(8'h7a, 16'h0000);
    for (int i = 0; i < 7; i++) begin
      host.sel(8'h01);
      @(negedge ref_clk);
      ev = 7'(1 << i);
      @(negedge ref_clk);
      ev = '0;
      rchk(FC[i], {8'h00, FB[i]});
      host.sel(8'h00);
      rchk(FC[i], i >= 5 ? {8'h00, FB[i]} : 16'h0000);
      ev0 = 5'(1 << i);
      @(negedge ref_clk);
      ev0 = '0;
      rchk(FC[i], {8'h00, FB[i]});
      host.sel(8'hff);
      wcmd(FC[i], 16'h00ff);
      rchk(FC[i], 16'h0000);
    end
    for (int i = 0; i < 20; i++) begin
      m = DF[i][15:8] == 8'h00 ? 16'h00ff : 16'hffff;
      r0 = rnd();
      r1 = rnd();
      host.sel(8'h00);
      wcmd(CD[i], r0);
      host.sel(8'h01);
      wcmd(CD[i], r1);
      rchk(CD[i], r1 & m);
      host.sel(8'h00);
      rchk(CD[i], ((CD[i] == 8'h55 || CD[i] == 8'h58) ? r1 : r0) & m);
    end
    host.sel(8'hff);
    wcmd(8'h46, 16'h1234);
    host.sel(8'h01);
    rchk(8'h46, 16'h1234);
    host.xfer(1'b1, 8'h00, 16'h0005, rd, ok);
    chk({15'h0, ok}, 16'h0000, "bad page refused");
    rchk(8'h00, 16'h0001);
    host.xfer(1'b0, 8'h99, 16'h0000, rd, ok);
    chk({15'h0, ok}, 16'h0000, "unknown code refused");
    wcmd(8'h15, 16'h0000);
    wcmd(8'h46, 16'h4321);
    wcmd(8'h16, 16'h0000);
    rchk(8'h46, 16'h1234);
    close_out();
  end
endmodule // fault_limit_sequencing_cmds_tb_top
bind flsc_top flsc_checker #(.CHANNELS(CHANNELS), .MS_CYCLES(MS_CYCLES)) chk_i (.*);
